/* logic/cpf_pkg.sv */
// Constants and types of the clock and power flag block
package cpf_pkg;

   // ======================================================
   // Register indexes and address width
   localparam logic [7:0]  IDX_SYNTH    = 8'h34;
   localparam logic [7:0]  IDX_POST_DIV = 8'h36;
   localparam logic [7:0]  IDX_FLAGS    = 8'h37;
   localparam logic [7:0]  IDX_ENABLE   = 8'h38;
   localparam logic [7:0]  IDX_CLEAR    = 8'h3C;
   localparam int          ADDR_W       = 10;

   // ======================================================
   // Flag bit positions
   localparam int B_TICK  = 7;
   localparam int B_POR   = 6;
   localparam int B_LVR   = 5;
   localparam int B_LCHG  = 4;
   localparam int B_LOCK  = 3;
   localparam int B_ILA   = 2;
   localparam int B_OCHG  = 1;
   localparam int B_QUAL  = 0;

   // ======================================================
   // Reset values and masks
   localparam logic [7:0] FLAGS_RST   = 8'h60;
   localparam logic [7:0] W1C_MASK    = 8'hF6;
   localparam logic [7:0] IRQ_MASK    = 8'h92;
   localparam logic [7:0] ENABLE_RST  = 8'h00;
   localparam logic [4:0] POST_DIV_RST = 5'h03;
   localparam logic [4:0] UNLOCK_DIV  = 5'h03;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================
   // Pin levels from outside the clock domain
   typedef struct packed {
      logic lvr;
      logic ila;
      logic lock;
      logic osc_good;
   } cpf_pins_type;

   // Mode requests from the stop logic
   typedef struct packed {
      logic full_stop;
      logic pseudo_stop;
   } cpf_mode_type;

endpackage : cpf_pkg

/* logic/cpf_top.sv */
// Clock and power flag register with AXI4-Lite slave
`timescale 1ns/1ns
module cpf_top
(
   input  wire logic                        clock_i,
   input  wire logic                        rst_n_i,
   // AXI4-Lite slave
   input  wire logic [cpf_pkg::ADDR_W-1:0]  s_awaddr_i,
   input  wire logic                        s_awvalid_i,
   output logic                             s_awready_o,
   input  wire logic [31:0]                 s_wdata_i,
   input  wire logic [3:0]                  s_wstrb_i,
   input  wire logic                        s_wvalid_i,
   output logic                             s_wready_o,
   output logic [1:0]                       s_bresp_o,
   output logic                             s_bvalid_o,
   input  wire logic                        s_bready_i,
   input  wire logic [cpf_pkg::ADDR_W-1:0]  s_araddr_i,
   input  wire logic                        s_arvalid_i,
   output logic                             s_arready_o,
   output logic [31:0]                      s_rdata_o,
   output logic [1:0]                       s_rresp_o,
   output logic                             s_rvalid_o,
   input  wire logic                        s_rready_i,
   // Pins from outside the clock domain
   input  wire cpf_pkg::cpf_pins_type       pins_i,
   // Same-domain events
   input  wire logic                        tick_end_i,
   input  wire cpf_pkg::cpf_mode_type       mode_i,
   // Outputs
   output logic [4:0]                       pll_div_minus1_o,
   output logic                             pll_active_o,
   output logic                             can_osc_clk_en_o,
   output logic                             irq_o
);
   import cpf_pkg::*;

   // ======================================================
   // Address decode
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[ADDR_W-1:2];
   endfunction : reg_index

   // ======================================================
   // Pin synchronisers
   cpf_pins_type pins_meta_r;
   cpf_pins_type pins_r;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pins_meta_r <= '0;
         pins_r      <= '0;
      end
      else
      begin
         pins_meta_r <= pins_i;
         pins_r      <= pins_meta_r;
      end
   end

   // ======================================================
   // Write channel
   logic                 aw_held_r;
   logic [ADDR_W-1:0]    aw_addr_r;
   logic                 w_held_r;
   logic [31:0]          w_data_r;
   logic                 w_lane0_r;
   logic                 wr_go;
   logic [7:0]           wr_idx;

   assign wr_go  = aw_held_r && w_held_r && !s_bvalid_o;
   assign wr_idx = reg_index(aw_addr_r);

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_held_r   <= 1'b0;
         aw_addr_r   <= '0;
         s_awready_o <= 1'b0;
      end
      else
      begin
         s_awready_o <= !aw_held_r && !s_awready_o;
         if (s_awvalid_i && s_awready_o)
         begin
            aw_held_r   <= 1'b1;
            aw_addr_r   <= s_awaddr_i;
            s_awready_o <= 1'b0;
         end
         else if (wr_go)
            aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         w_held_r   <= 1'b0;
         w_data_r   <= '0;
         w_lane0_r  <= 1'b0;
         s_wready_o <= 1'b0;
      end
      else
      begin
         s_wready_o <= !w_held_r && !s_wready_o;
         if (s_wvalid_i && s_wready_o)
         begin
            w_held_r   <= 1'b1;
            w_data_r   <= s_wdata_i;
            w_lane0_r  <= s_wstrb_i[0];
            s_wready_o <= 1'b0;
         end
         else if (wr_go)
            w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_bvalid_o <= 1'b0;
         s_bresp_o  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_bvalid_o <= 1'b1;
         unique case (wr_idx)
            IDX_SYNTH, IDX_POST_DIV, IDX_FLAGS, IDX_ENABLE, IDX_CLEAR:
               s_bresp_o <= RESP_OKAY;
            default:
               s_bresp_o <= RESP_SLVERR;
         endcase
      end
      else if (s_bready_i)
         s_bvalid_o <= 1'b0;
   end

   // Register write strobes, byte lane 0 only
   logic       wr_en;
   logic [7:0] wr_byte;
   assign wr_en   = wr_go && w_lane0_r;
   assign wr_byte = w_data_r[7:0];

   // ======================================================
   // Control registers
   logic [7:0] enable_r;
   logic [4:0] post_div_r;
   logic [7:0] synth_r;
   logic       synth_wr;

   assign synth_wr = wr_en && (wr_idx == IDX_SYNTH);

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         enable_r   <= ENABLE_RST;
         post_div_r <= POST_DIV_RST;
         synth_r    <= '0;
      end
      else if (wr_en)
      begin
         if (wr_idx == IDX_ENABLE)
            enable_r <= wr_byte & IRQ_MASK;
         if (wr_idx == IDX_POST_DIV)
            post_div_r <= wr_byte[4:0];
         if (wr_idx == IDX_SYNTH)
            synth_r <= wr_byte;
      end
   end

   // ======================================================
   // Lock and oscillator status
   logic lock_r;
   logic lock_nxt;
   logic qual_r;
   logic qual_nxt;

   always_comb
   begin
      lock_nxt = pins_r.lock;
      if (synth_wr)
         lock_nxt = 1'b0;
   end

   always_comb
   begin
      qual_nxt = qual_r;
      if (mode_i.full_stop)
         qual_nxt = 1'b0;
      else if (synth_wr)
         qual_nxt = 1'b0;
      else if (!lock_nxt && !mode_i.pseudo_stop)
         qual_nxt = 1'b0;
      else if (lock_nxt)
         qual_nxt = pins_r.osc_good;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_r <= 1'b0;
         qual_r <= 1'b0;
      end
      else
      begin
         lock_r <= lock_nxt;
         qual_r <= qual_nxt;
      end
   end

   // ======================================================
   // Sticky flags
   logic [7:0] flags_r;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;

   always_comb
   begin
      set_vec         = '0;
      set_vec[B_TICK] = tick_end_i;
      set_vec[B_LVR]  = pins_r.lvr;
      set_vec[B_ILA]  = pins_r.ila;
      set_vec[B_LCHG] = lock_nxt != lock_r;
      set_vec[B_OCHG] = qual_nxt != qual_r;
   end

   assign clr_vec = (wr_en && (wr_idx == IDX_FLAGS || wr_idx == IDX_CLEAR))
                    ? (wr_byte & W1C_MASK) : 8'h00;

   // Power-on reset values: POR and LVR set, ILA cleared
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flags_r <= FLAGS_RST;
      else
         flags_r <= (flags_r & ~clr_vec) | set_vec;
   end

   // ======================================================
   // Read channel
   logic [7:0] status_byte;
   always_comb
   begin
      status_byte         = flags_r & W1C_MASK;
      status_byte[B_LOCK] = lock_r;
      status_byte[B_QUAL] = qual_r;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_arready_o <= 1'b0;
         s_rvalid_o  <= 1'b0;
         s_rdata_o   <= '0;
         s_rresp_o   <= RESP_OKAY;
      end
      else
      begin
         s_arready_o <= !s_rvalid_o && !s_arready_o && !s_arvalid_i ? 1'b1
                        : (!s_rvalid_o && !s_arready_o);
         if (s_arvalid_i && s_arready_o)
         begin
            s_arready_o <= 1'b0;
            s_rvalid_o  <= 1'b1;
            s_rresp_o   <= RESP_OKAY;
            s_rdata_o   <= '0;
            unique case (reg_index(s_araddr_i))
               IDX_SYNTH:   s_rdata_o[7:0] <= synth_r;
               IDX_POST_DIV: s_rdata_o[4:0] <= post_div_r;
               IDX_FLAGS:   s_rdata_o[7:0] <= status_byte;
               IDX_ENABLE:  s_rdata_o[7:0] <= enable_r;
               IDX_CLEAR:   s_rdata_o[7:0] <= 8'h00;
               default:     s_rresp_o      <= RESP_SLVERR;
            endcase
         end
         else if (s_rvalid_o && s_rready_i)
            s_rvalid_o <= 1'b0;
      end
   end

   // ======================================================
   // Clock control outputs and interrupt
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pll_div_minus1_o <= UNLOCK_DIV;
         pll_active_o     <= 1'b1;
         can_osc_clk_en_o <= 1'b0;
         irq_o            <= 1'b0;
      end
      else
      begin
         pll_div_minus1_o <= lock_nxt ? post_div_r : UNLOCK_DIV;
         pll_active_o     <= 1'b1;
         can_osc_clk_en_o <= qual_nxt;
         irq_o            <= |(((flags_r & ~clr_vec) | set_vec) & enable_r
                                & IRQ_MASK);
      end
   end

endmodule : cpf_top

/* tb/clock_power_flags_bench.sv */
// Self-checking bench of the clock and power flag block
`timescale 1ns/1ns
module clock_power_flags_bench;
   import cpf_pkg::*;
   localparam logic [9:0] A_SYN = {IDX_SYNTH, 2'b00};
   localparam logic [9:0] A_PDV = {IDX_POST_DIV, 2'b00};
   localparam logic [9:0] A_FLG = {IDX_FLAGS, 2'b00};
   localparam logic [9:0] A_ENA = {IDX_ENABLE, 2'b00};
   localparam logic [9:0] A_CLR = {IDX_CLEAR, 2'b00};
   logic         clock_i, rst_n_i, awv, wv, bready, arv, rready, tick;
   logic         awready, wready, bvalid, arready, rvalid, active, can_en, irq;
   logic [9:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, rd;
   logic [1:0]   bresp, rresp, rs;
   logic [4:0]   div;
   logic [3:0]   strb;
   cpf_pins_type pins;
   cpf_mode_type mode;
   int           miscompares, num_checks;
   wire  [31:0]  outs = {24'h0, irq, can_en, active, div};
   cpf_top cpf_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .s_awaddr_i(awaddr),
      .s_awvalid_i(awv), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(strb),
      .s_wvalid_i(wv), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
      .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arv), .s_arready_o(arready),
      .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
      .pins_i(pins), .tick_end_i(tick), .mode_i(mode), .pll_div_minus1_o(div),
      .pll_active_o(active), .can_osc_clk_en_o(can_en), .irq_o(irq));
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   // ====================
   // Helpers
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_i);
   endtask : cyc
   task automatic wr(input logic [9:0] a, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hF);
      int         n;
      logic       ta, tw, tb;
      logic [1:0] bs;
      awaddr <= a;
      wdata  <= {24'h0, d};
      strb   <= s;
      awv    <= 1'b1;
      wv     <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(negedge clock_i);
         ta = awready;
         tw = wready;
         tb = bvalid & bready;
         bs = bresp;
         @(posedge clock_i);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) break;
         bready <= bvalid;
      end
      bready <= 1'b0;
      if (n == 99)
      begin
         miscompares++;
         complete_run();
      end
      chk({30'h0, bs}, {30'h0, er});
   endtask : wr
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e,
                         input logic [1:0] er = RESP_OKAY);
      int   n;
      logic ta, tr;
      araddr <= a;
      arv    <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(negedge clock_i);
         ta = arready;
         tr = rvalid & rready;
         rd = rdata;
         rs = rresp;
         @(posedge clock_i);
         if (ta) arv <= 1'b0;
         if (tr) break;
         rready <= rvalid;
      end
      rready <= 1'b0;
      if (n == 99)
      begin
         miscompares++;
         complete_run();
      end
      chk(rd, e);
      chk({30'h0, rs}, {30'h0, er});
   endtask : rd_chk
   // ====================
   // Scenarios
   task automatic t_reset();
      rd_chk(A_FLG, 32'h60);
      chk(outs, 32'h23);
   endtask : t_reset
   task automatic t_w1c();
      wr(A_FLG, 8'h00);
      rd_chk(A_FLG, 32'h60);
      wr(A_CLR, 8'h40);
      rd_chk(A_FLG, 32'h20);
      wr(A_FLG, 8'hFF);
      rd_chk(A_FLG, 32'h00);
      rd_chk(A_CLR, 32'h00);
   endtask : t_w1c
   task automatic t_cause();
      pins.lvr <= 1'b1;
      pins.ila <= 1'b1;
      cyc(4);
      pins.lvr <= 1'b0;
      pins.ila <= 1'b0;
      cyc(4);
      rd_chk(A_FLG, 32'h24);
      wr(A_CLR, 8'h24);
      rd_chk(A_FLG, 32'h00);
   endtask : t_cause
   task automatic t_tick();
      wr(A_ENA, 8'h80);
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      cyc(2);
      chk(outs, 32'hA3);
      rd_chk(A_FLG, 32'h80);
      wr(A_ENA, 8'h00);
      cyc(2);
      chk(outs, 32'h23);
      wr(A_ENA, 8'h80);
      rd_chk(A_ENA, 32'h80);
      chk(outs, 32'hA3);
      wr(A_CLR, 8'h80);
      cyc(2);
      chk(outs, 32'h23);
   endtask : t_tick
   task automatic t_lock();
      wr(A_PDV, 8'h05);
      pins.lock <= 1'b1;
      cyc(8);
      chk(outs, 32'h25);
      pins.osc_good <= 1'b1;
      cyc(4);
      chk(outs, 32'h65);
      rd_chk(A_FLG, 32'h1B);
      wr(A_FLG, 8'h09);
      rd_chk(A_FLG, 32'h1B);
      wr(A_ENA, 8'h12);
      cyc(2);
      chk(outs, 32'hE5);
      wr(A_CLR, 8'h12);
      rd_chk(A_FLG, 32'h09);
   endtask : t_lock
   task automatic t_stop();
      mode.full_stop <= 1'b1;
      cyc(1);
      mode.full_stop <= 1'b0;
      cyc(4);
      rd_chk(A_FLG, 32'h0B);
      wr(A_CLR, 8'h12);
      mode.pseudo_stop <= 1'b1;
      pins.lock        <= 1'b0;
      cyc(8);
      chk(outs, 32'hE3);
      rd_chk(A_FLG, 32'h11);
      mode.pseudo_stop <= 1'b0;
      cyc(8);
      chk(outs, 32'hA3);
      rd_chk(A_FLG, 32'h12);
      wr(A_CLR, 8'h12);
   endtask : t_stop
   task automatic t_synth();
      pins.lock <= 1'b1;
      cyc(8);
      wr(A_CLR, 8'h12);
      wr(A_SYN, 8'h01);
      cyc(8);
      rd_chk(A_FLG, 32'h1B);
      wr(A_ENA, 8'h00, RESP_OKAY, 4'hE);
      rd_chk(A_ENA, 32'h12);
      wr(10'h3FC, 8'hFF, RESP_SLVERR);
      rd_chk(A_FLG, 32'h1B);
      rd_chk(10'h3FC, 32'h00, RESP_SLVERR);
   endtask : t_synth
   initial
   begin
      miscompares = 0;
      num_checks  = 0;
      rst_n_i     = 1'b0;
      {awv, wv, bready, arv, rready, tick} = 6'h00;
      awaddr = 10'h000;
      araddr = 10'h000;
      wdata  = 32'h0;
      strb   = 4'hF;
      pins   = '0;
      mode   = '0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      cyc(1);
      t_reset();
      t_w1c();
      t_cause();
      t_tick();
      t_lock();
      t_stop();
      t_synth();
      complete_run();
   end
endmodule : clock_power_flags_bench

/* tb/cpf_top_sva.sv */
// Port assertions of the clock and power flag block
`timescale 1ns/1ns
module cpf_top_sva
(
   input wire logic                  clock_i,
   input wire logic                  rst_n_i,
   input wire logic                  s_arvalid_i,
   input wire logic                  s_arready_o,
   input wire logic                  s_rvalid_o,
   input wire logic                  s_rready_i,
   input wire logic [31:0]           s_rdata_o,
   input wire logic [1:0]            s_rresp_o,
   input wire logic                  s_bvalid_o,
   input wire logic                  s_bready_i,
   input wire logic [1:0]            s_bresp_o,
   input wire cpf_pkg::cpf_pins_type pins_i,
   input wire cpf_pkg::cpf_mode_type mode_i,
   input wire logic [4:0]            pll_div_minus1_o,
   input wire logic                  pll_active_o,
   input wire logic                  can_osc_clk_en_o,
   input wire logic                  irq_o
);
   import cpf_pkg::*;
   // ====================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_pll_always_on: assert property (pll_active_o)
      else $error("pll active dropped");
   a_unlock_div_four: assert property (!pins_i.lock [*6] |-> pll_div_minus1_o == 5'h03)
      else $error("unlocked divider not four");
   a_lock_loss_qual: assert property ((!pins_i.lock && !mode_i.pseudo_stop) [*7]
      |-> !can_osc_clk_en_o) else $error("qualified kept after lock loss");
   a_osc_bad_gate: assert property ((pins_i.lock && !pins_i.osc_good) [*7]
      |-> !can_osc_clk_en_o) else $error("can clock open with bad oscillator");
   a_full_stop_clear: assert property (mode_i.full_stop |-> ##[1:2] !can_osc_clk_en_o)
      else $error("full stop left oscillator qualified");
   a_read_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
      else $error("read answer late");
   a_rvalid_hold: assert property (s_rvalid_o && !s_rready_i
      |=> s_rvalid_o && $stable(s_rdata_o) && $stable(s_rresp_o)) else $error("read dropped");
   a_bvalid_hold: assert property (s_bvalid_o && !s_bready_i
      |=> s_bvalid_o && $stable(s_bresp_o)) else $error("write response dropped");
   c_irq: cover property ($rose(irq_o));
   c_slverr: cover property (s_rvalid_o && s_rresp_o == RESP_SLVERR);
   c_gate: cover property ($fell(can_osc_clk_en_o));
endmodule : cpf_top_sva
bind cpf_top cpf_top_sva cpf_top_sva_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o), .s_rvalid_o(s_rvalid_o),
   .s_rready_i(s_rready_i), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
   .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i), .s_bresp_o(s_bresp_o),
   .pins_i(pins_i), .mode_i(mode_i), .pll_div_minus1_o(pll_div_minus1_o),
   .pll_active_o(pll_active_o), .can_osc_clk_en_o(can_osc_clk_en_o), .irq_o(irq_o));
